// >>> ram_bridge_pkg.sv
package ram_bridge_pkg;

  // Register offsets (byte addresses, low byte of haddr)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFS_DATA_LOW = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;

  // Control field positions
  localparam int CTL_WRITE_SELECT = 0;
  localparam int CTL_ACCESS_REQUEST = 1;
  localparam int CTL_IRQ_ENABLE = 2;
  localparam int CTL_SPACE_Y = 3;
  localparam int CTL_PAIR = 4;

  // Status field positions
  localparam int STS_NEW_STATUS = 0;
  localparam int STS_IRQ_ACTIVE = 1;
  localparam int STS_BUSY = 2;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Cycles the device spends inside the RAM before completing
  localparam int ACCESS_CYCLES = 2;

  typedef struct packed {
    logic pair;
    logic space_y;
    logic irq_enable;
    logic access_request;
    logic write_select;
  } control_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_phase_type;

  localparam control_type RST_CONTROL = '{default: 1'b0};
  localparam bus_phase_type RST_PHASE = '{valid: 1'b0, write: 1'b0, addr: 8'h00};

endpackage

// >>> dsp_ram_indirect_access.sv
`timescale 1ns/10ps
module dsp_ram_indirect_access #(
  parameter int RAM_ADDR_W = 9
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Interrupt request
  output logic irq
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_BUSY = 3'b010,
    ST_DONE = 3'b100
  } state_type;

  localparam int RAM_DEPTH = 1 << RAM_ADDR_W;
  localparam int CNT_W = $clog2(ram_bridge_pkg::ACCESS_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ram_bridge_pkg::ACCESS_CYCLES - 1);

  state_type state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r;
  ram_bridge_pkg::control_type control_r;
  ram_bridge_pkg::bus_phase_type phase_r;
  logic [7:0] addr_high_r, addr_low_r, data_high_r, data_low_r;
  logic new_status_r, irq_r, hreadyout_r;
  logic [31:0] hrdata_r;
  logic [7:0] ram_x [RAM_DEPTH];
  logic [7:0] ram_y [RAM_DEPTH];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  // Bus decode
  wire addr_take = hsel & hready & htrans[1];
  wire wr_now = phase_r.valid & phase_r.write & hready;
  wire idle = state_r == ST_IDLE;
  // Holding setup registers while busy keeps an in-flight transfer consistent
  wire setup_ok = wr_now & idle;
  wire wr_control = wr_now & hit(phase_r.addr, ram_bridge_pkg::OFS_CONTROL);
  wire wr_status = wr_now & hit(phase_r.addr, ram_bridge_pkg::OFS_STATUS);
  wire start = setup_ok & wr_control & hwdata[ram_bridge_pkg::CTL_ACCESS_REQUEST];
  wire finish = state_r == ST_DONE;

  // RAM addressing: pair transfers use addr (LSB) and addr+1 (MSB)
  wire [RAM_ADDR_W-1:0] ram_lo = RAM_ADDR_W'({addr_high_r, addr_low_r});
  wire [RAM_ADDR_W-1:0] ram_hi = ram_lo + RAM_ADDR_W'(1);
  wire [7:0] rd_lo = control_r.space_y ? ram_y[ram_lo] : ram_x[ram_lo];
  wire [7:0] rd_hi = control_r.space_y ? ram_y[ram_hi] : ram_x[ram_hi];
  wire ram_wr = finish & control_r.write_select;
  wire ram_rd = finish & ~control_r.write_select;

  // New status: a set in the same cycle as a clear wins
  wire status_clr = wr_status & ~hwdata[ram_bridge_pkg::STS_NEW_STATUS];
  wire new_status_nxt = finish | (new_status_r & ~status_clr);

  wire [31:0] control_rd = {27'h000_0000, control_r};
  wire [31:0] status_rd = {29'h0000_0000, ~idle, irq_r, new_status_r};
  wire [31:0] rdata =
    hit(phase_r.addr, ram_bridge_pkg::OFS_CONTROL) ? control_rd :
    hit(phase_r.addr, ram_bridge_pkg::OFS_ADDR_HIGH) ? {24'h00_0000, addr_high_r} :
    hit(phase_r.addr, ram_bridge_pkg::OFS_ADDR_LOW) ? {24'h00_0000, addr_low_r} :
    hit(phase_r.addr, ram_bridge_pkg::OFS_DATA_HIGH) ? {24'h00_0000, data_high_r} :
    hit(phase_r.addr, ram_bridge_pkg::OFS_DATA_LOW) ? {24'h00_0000, data_low_r} :
    hit(phase_r.addr, ram_bridge_pkg::OFS_STATUS) ? status_rd : ram_bridge_pkg::RST_WORD;

  always_comb begin
    case (state_r)
      ST_IDLE: state_nxt = start ? ST_BUSY : ST_IDLE;
      ST_BUSY: state_nxt = (cnt_r == '0) ? ST_DONE : ST_BUSY;
      ST_DONE: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Bus phase tracking; reads take one wait state so write data is never stale
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_r <= ram_bridge_pkg::RST_PHASE;
      hreadyout_r <= 1'b1;
      hrdata_r <= ram_bridge_pkg::RST_WORD;
    end else begin
      if (hreadyout_r) begin
        phase_r <= '{valid: addr_take, write: hwrite, addr: haddr[7:0]};
        hreadyout_r <= ~(addr_take & ~hwrite);
      end else begin
        hrdata_r <= rdata;
        hreadyout_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= start ? CNT_LOAD : (cnt_r == '0 ? cnt_r : cnt_r - CNT_W'(1));
    end
  end

  // Control register: request bit is cleared only by the device
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      control_r <= ram_bridge_pkg::RST_CONTROL;
    end else begin
      if (wr_control) begin
        control_r.irq_enable <= hwdata[ram_bridge_pkg::CTL_IRQ_ENABLE];
      end
      if (setup_ok & wr_control) begin
        control_r.write_select <= hwdata[ram_bridge_pkg::CTL_WRITE_SELECT];
        control_r.space_y <= hwdata[ram_bridge_pkg::CTL_SPACE_Y];
        control_r.pair <= hwdata[ram_bridge_pkg::CTL_PAIR];
      end
      if (start) begin
        control_r.access_request <= 1'b1;
      end else if (finish) begin
        control_r.access_request <= 1'b0;
      end
    end
  end

  // Address and data registers; a read transfer refills data low, and data high too when pair is set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_high_r <= ram_bridge_pkg::RST_BYTE;
      addr_low_r <= ram_bridge_pkg::RST_BYTE;
      data_high_r <= ram_bridge_pkg::RST_BYTE;
      data_low_r <= ram_bridge_pkg::RST_BYTE;
    end else if (ram_rd) begin
      data_low_r <= rd_lo;
      if (control_r.pair) begin
        data_high_r <= rd_hi;
      end
    end else if (setup_ok) begin
      if (hit(phase_r.addr, ram_bridge_pkg::OFS_ADDR_HIGH)) addr_high_r <= hwdata[7:0];
      if (hit(phase_r.addr, ram_bridge_pkg::OFS_ADDR_LOW)) addr_low_r <= hwdata[7:0];
      if (hit(phase_r.addr, ram_bridge_pkg::OFS_DATA_HIGH)) data_high_r <= hwdata[7:0];
      if (hit(phase_r.addr, ram_bridge_pkg::OFS_DATA_LOW)) data_low_r <= hwdata[7:0];
    end
  end

  // DSP RAM storage, one space per transfer
  always_ff @(posedge hclk) begin
    if (ram_wr & ~control_r.space_y) begin
      ram_x[ram_lo] <= data_low_r;
      if (control_r.pair) ram_x[ram_hi] <= data_high_r;
    end
    if (ram_wr & control_r.space_y) begin
      ram_y[ram_lo] <= data_low_r;
      if (control_r.pair) ram_y[ram_hi] <= data_high_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      new_status_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      new_status_r <= new_status_nxt;
      irq_r <= new_status_r & control_r.irq_enable;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;
  assign irq = irq_r;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_start_to_done: assert property (start |-> ##1 (state_r == ST_BUSY)[*2] ##1 finish)
    else $error("transfer did not complete in time");
  a_done_clears_req: assert property (finish |=> !control_r.access_request && new_status_r)
    else $error("completion did not clear request and set status");
  a_irq_follows: assert property (##1 irq == $past(new_status_r && control_r.irq_enable))
    else $error("irq does not follow status and enable");
  a_irq_drops: assert property (status_clr && !finish |=> !new_status_r ##1 !irq)
    else $error("status clear did not release irq");
  a_set_wins: assert property (finish && status_clr |=> new_status_r)
    else $error("completion lost to a clear");
  a_pair_order: assert property (ram_rd && control_r.pair |=> data_high_r == $past(rd_hi)
    && data_low_r == $past(rd_lo))
    else $error("pair read bytes misplaced");
  a_read_fill: assert property (ram_rd && !control_r.pair |=> data_low_r == $past(rd_lo))
    else $error("read did not fill low data");
  a_setup_held: assert property (!idle && !ram_rd |=> $stable(addr_low_r) && $stable(data_low_r))
    else $error("setup changed during transfer");
  a_read_wait: assert property (addr_take && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");

  c_write_done: cover property (ram_wr && control_r.pair);
  c_read_done: cover property (ram_rd && control_r.space_y);
  c_irq_cycle: cover property (irq ##[1:20] !irq);

endmodule

// >>> ram_host.sv
`timescale 1ns/10ps
module ram_host (
  // Bus clock and answer
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Bus request
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // Slave outputs move only at rising edges, so the low phase shows what the next edge samples
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic r;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, a};
    do begin
      @(negedge hclk);
      r = hready;
      @(posedge hclk);
    end while (r !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // Reads see a changing pattern, never stale write data
    hwdata <= w ? d : ~hwdata;
    do begin
      @(negedge hclk);
      r = hready;
      q = hrdata;
      @(posedge hclk);
    end while (r !== 1'b1);
  endtask
endmodule

// >>> dsp_ram_indirect_access_test.sv
`timescale 1ns/10ps
module dsp_ram_indirect_access_test;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  int n_fail = 0;
  int cmp_count = 0;

  dsp_ram_indirect_access u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .irq(irq));
  ram_host u_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask

  function automatic logic [31:0] ctl(input logic w, go, ie, y, p);
    ctl = 32'h0000_0000;
    ctl[ram_bridge_pkg::CTL_WRITE_SELECT] = w;
    ctl[ram_bridge_pkg::CTL_ACCESS_REQUEST] = go;
    ctl[ram_bridge_pkg::CTL_IRQ_ENABLE] = ie;
    ctl[ram_bridge_pkg::CTL_SPACE_Y] = y;
    ctl[ram_bridge_pkg::CTL_PAIR] = p;
  endfunction

  // Full host sequence: setup, request, completion, irq service
  task automatic access(input logic w, y, p, ie, input logic [15:0] a, input logic [7:0] hi, lo);
    int n;
    n = 0;
    wr(ram_bridge_pkg::OFS_CONTROL, ctl(w, 1'b0, ie, y, p));
    wr(ram_bridge_pkg::OFS_ADDR_HIGH, 32'(a[15:8]));
    wr(ram_bridge_pkg::OFS_ADDR_LOW, 32'(a[7:0]));
    if (w) begin
      wr(ram_bridge_pkg::OFS_DATA_HIGH, 32'(hi));
      wr(ram_bridge_pkg::OFS_DATA_LOW, 32'(lo));
    end
    wr(ram_bridge_pkg::OFS_CONTROL, ctl(w, 1'b1, ie, y, p));
    rd(ram_bridge_pkg::OFS_STATUS);
    while (q[ram_bridge_pkg::STS_NEW_STATUS] !== 1'b1 && n < 20) begin
      rd(ram_bridge_pkg::OFS_STATUS);
      n++;
    end
    chk("new_status_flag", 32'h1, 32'(q[ram_bridge_pkg::STS_NEW_STATUS]));
    chk("new_status_irq_active", 32'(ie), 32'(q[ram_bridge_pkg::STS_IRQ_ACTIVE]));
    repeat (2) @(posedge hclk);
    #1;
    chk("irq", 32'(ie), 32'(irq));
    rd(ram_bridge_pkg::OFS_CONTROL);
    chk("ram_access_request", 32'h0, 32'(q[ram_bridge_pkg::CTL_ACCESS_REQUEST]));
    wr(ram_bridge_pkg::OFS_STATUS, 32'h0000_0000);
    repeat (2) @(posedge hclk);
    #1;
    chk("irq", 32'h0, 32'(irq));
    rd(ram_bridge_pkg::OFS_STATUS);
    chk("status", 32'h0, q);
  endtask

  task automatic t_reset;
    logic [7:0] ofs [7] = '{ram_bridge_pkg::OFS_CONTROL, ram_bridge_pkg::OFS_ADDR_HIGH,
      ram_bridge_pkg::OFS_ADDR_LOW, ram_bridge_pkg::OFS_DATA_HIGH, ram_bridge_pkg::OFS_DATA_LOW,
      ram_bridge_pkg::OFS_STATUS, 8'h40};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk("reset_value", 32'h0000_0000, q);
    end
    chk("irq", 32'h0, 32'(irq));
    chk("hresp", 32'h0, 32'(hresp));
    $display("t_reset done");
  endtask

  task automatic t_byte;
    access(1'b1, 1'b0, 1'b0, 1'b0, 16'h0123, 8'h00, 8'hA5);
    access(1'b0, 1'b0, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h00);
    rd(ram_bridge_pkg::OFS_DATA_LOW);
    chk("ram_data_low", 32'h0000_00A5, q);
    $display("t_byte done");
  endtask

  task automatic t_pair;
    access(1'b1, 1'b0, 1'b1, 1'b1, 16'h0040, 8'h12, 8'h34);
    access(1'b0, 1'b0, 1'b0, 1'b0, 16'h0041, 8'h00, 8'h00);
    rd(ram_bridge_pkg::OFS_DATA_LOW);
    chk("msb_at_high_address", 32'h0000_0012, q);
    access(1'b0, 1'b0, 1'b1, 1'b1, 16'h0040, 8'h00, 8'h00);
    rd(ram_bridge_pkg::OFS_DATA_HIGH);
    chk("ram_data_high", 32'h0000_0012, q);
    rd(ram_bridge_pkg::OFS_DATA_LOW);
    chk("ram_data_low", 32'h0000_0034, q);
    $display("t_pair done");
  endtask

  task automatic t_space;
    access(1'b1, 1'b1, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h5A);
    access(1'b0, 1'b0, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h00);
    rd(ram_bridge_pkg::OFS_DATA_LOW);
    chk("x_word", 32'h0000_00A5, q);
    access(1'b0, 1'b1, 1'b0, 1'b0, 16'h0123, 8'h00, 8'h00);
    rd(ram_bridge_pkg::OFS_DATA_LOW);
    chk("y_word", 32'h0000_005A, q);
    $display("t_space done");
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    wrap_up;
  end

  initial begin
    hresetn = 1'b0;
    q = 32'h0000_0000;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_byte;
    t_pair;
    t_space;
    wrap_up;
  end
endmodule
